// [rtl/midt_pkg.sv]
// shared constants and types of the instruction decode and timing block
package midt_pkg;
    // instruction cycle framing, counted in oscillator periods of clk_sys
    localparam int OSC_PER_CYCLE = 4;
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_LAST = 2'(OSC_PER_CYCLE - 1);
    // top nibble of an instruction word
    localparam logic [3:0] NIB_BYTE_HI = 4'h5;
    localparam logic [3:0] NIB_BIT_HI = 4'h8;
    localparam logic [3:0] NIB_BIT_TEST = 4'h8;
    localparam logic [3:0] NIB_LIT = 4'h9;
    localparam logic [3:0] NIB_CTRL = 4'hA;
    localparam logic [3:0] NIB_DW_PTR = 4'hB;
    localparam logic [3:0] NIB_DW_MOVE = 4'hC;
    localparam logic [3:0] NIB_DW_CALL = 4'hD;
    localparam logic [3:0] NIB_DW_GOTO = 4'hE;
    localparam logic [3:0] NIB_SECOND = 4'hF;
    // sub operation in bits 11:8 of literal and control words
    localparam logic [3:0] SUB_CBR_MAX = 4'h7;
    localparam logic [3:0] SUB_RETURN = 4'h8;
    localparam logic [3:0] SUB_TABLE = 4'h9;
    localparam logic [3:0] SUB_NONE = 4'hA;
    localparam logic [3:0] SUB_JUMP = 4'hB;
    localparam logic [3:0] SUB_EXT_LO = 4'hC;
    // access bank split for unbanked register addresses
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CYCLES = 8'h08;
    localparam logic [7:0] OFS_LASTWORD = 8'h0C;
    // control fields and reset values
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_CLR_BIT = 8;
    localparam logic CTRL_EXT_RST = 1'b0;
    // status fields
    localparam int STS_CLS_LSB = 0;
    localparam int STS_NOP_BIT = 3;
    localparam int STS_SEQ_BIT = 4;
    localparam int STS_JMP_BIT = 5;
    localparam int STS_CND_BIT = 6;
    localparam int STS_EXT_BIT = 7;
    // decoded instruction classes
    typedef enum logic [2:0] {CLS_NOP, CLS_BYTE, CLS_BIT, CLS_LIT, CLS_CTRL, CLS_DWORD} midt_class_t;
    // sequencer states
    typedef enum logic {SQ_EXEC, SQ_WORD2} midt_seq_t;
    // table pointer step modes, in field order
    typedef enum logic [1:0] {TBL_KEEP, TBL_POSTINC, TBL_POSTDEC, TBL_PREINC} midt_tbl_t;
endpackage

// [rtl/midt_phase_gen.sv]
// oscillator period counter that frames each instruction cycle
`timescale 1ns/1ns
module midt_phase_gen import midt_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // phase within the instruction cycle
    output logic [1:0] phase,
    output logic cycEnd
);
    typedef struct packed {
        logic [1:0] phase;
    } midt_ph_t;

    midt_ph_t st_r;
    midt_ph_t st_nxt;

    // four periods, wrapping; the last one closes the cycle
    always_comb begin
        st_nxt = st_r;
        st_nxt.phase = (st_r.phase == PH_LAST) ? PH_FIRST : st_r.phase + 2'h1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign phase = st_r.phase;
    assign cycEnd = (st_r.phase == PH_LAST);
endmodule

// [rtl/midt_decoder.sv]
// instruction decoder and cycle sequencer of the 8-bit core
// Operation
// - decode 75 base plus 8 extended instructions
// - words are 16 bits; four take two
// - split word into opcode and operand fields
// - four classes, each routing its own fields
// - byte ops: register, destination, access selector
// - destination zero to accumulator, one to register
// - bit ops: register, bit number, access selector
// - literal ops: constant, pointer select, or none
// - control ops: address, shadow, table mode, none
// - lone second word executes as no-operation
// - taken test or jump adds nop cycle
// - double-word instructions take two cycles
// - instruction cycle equals four oscillator periods
// - taken skip over double word: three cycles
// - access selector picks access bank or bank register
// - 8-bit short address, 12-bit move addresses
// - table mode: keep, postinc, postdec, preinc
// - shadow selector one saves, zero untouched
`timescale 1ns/1ns
module midt_decoder import midt_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // program memory side
    input wire logic [15:0] instrWord,
    output logic fetchReq,
    output logic [1:0] cycPhase,
    // datapath feedback
    input wire logic condTrue,
    input wire logic [3:0] bankSelectReg,
    // issue strobe for one period; decoded instruction held for one instruction cycle
    output logic issueStb,
    output logic nopCycle,
    output midt_class_t instrClass,
    output logic [5:0] opcField,
    output logic [7:0] fileAddr,
    output logic [11:0] effAddr,
    output logic bankedAccess,
    output logic destToFile,
    output logic [2:0] bitSel,
    output logic [11:0] literalVal,
    output logic [1:0] indirectPointerSel,
    output logic indirectPointerLoad,
    output logic condEval,
    output logic [2:0] condCode,
    output logic [7:0] relOffset,
    output logic pcLoad,
    output logic [19:0] progAddr,
    output logic shadowUpd,
    output logic tableOp,
    output midt_tbl_t tableAddressPointerMode,
    output logic [11:0] srcAddr,
    output logic [11:0] dstAddr,
    output logic workingAccumulatorWr,
    output logic fileWr,
    output logic extOp,
    output logic [2:0] extIdx,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    typedef struct packed {
        midt_seq_t seq;
        logic pendCond;
        logic pendJump;
        logic [15:0] word1;
        logic fetch;
        logic issue;
        logic nop;
        midt_class_t cls;
        logic [5:0] opc;
        logic [7:0] fileAddr;
        logic [11:0] effAddr;
        logic banked;
        logic destFile;
        logic [2:0] bitSel;
        logic [11:0] literal;
        logic [1:0] ptrSel;
        logic ptrLoad;
        logic condEval;
        logic [2:0] condCode;
        logic [7:0] relOff;
        logic pcLoad;
        logic [19:0] progAddr;
        logic shadow;
        logic tblOp;
        midt_tbl_t tblMode;
        logic [11:0] srcAddr;
        logic [11:0] dstAddr;
        logic wrAcc;
        logic wrFile;
        logic extOp;
        logic [2:0] extIdx;
        logic extEn;
        logic [15:0] cycCnt;
        logic [15:0] lastWord;
        logic [31:0] rdData;
    } midt_state_t;

    midt_state_t st_r;
    midt_state_t st_nxt;
    logic [1:0] phase;
    logic cycEnd;
    logic killWord;

    // first word of a double-word instruction
    function automatic logic isDword(input logic [15:0] w);
        isDword = (w[15:12] >= NIB_DW_PTR) && (w[15:12] != NIB_SECOND);
    endfunction

    // class from the top nibble; a lone second word falls to nop
    function automatic midt_class_t classOf(input logic [15:0] w);
        if (w[15:12] <= NIB_BYTE_HI) begin
            classOf = CLS_BYTE;
        end else if (w[15:12] <= NIB_BIT_HI) begin
            classOf = CLS_BIT;
        end else if (w[15:12] == NIB_LIT) begin
            classOf = CLS_LIT;
        end else if (w[15:12] == NIB_CTRL) begin
            classOf = CLS_CTRL;
        end else if (isDword(w)) begin
            classOf = CLS_DWORD;
        end else begin
            classOf = CLS_NOP;
        end
    endfunction

    // unbanked addresses split between the two halves of the access bank
    function automatic logic [11:0] bankAddr(input logic a, input logic [7:0] f, input logic [3:0] bank);
        if (a) begin
            bankAddr = {bank, f};
        end else begin
            bankAddr = {(f >= ACC_SPLIT) ? ACC_HI_BANK : ACC_LO_BANK, f};
        end
    endfunction

    midt_phase_gen u_phase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .phase(phase),
        .cycEnd(cycEnd)
    );

    // the word fetched behind a taken test or a jump is stale
    assign killWord = st_r.pendJump | (st_r.pendCond & condTrue);

    // next state: register port, cycle counter and the per-cycle decode
    always_comb begin
        st_nxt = st_r;
        st_nxt.issue = 1'b0;
        st_nxt.fetch = 1'b0;
        st_nxt.rdData = 32'h0000_0000;
        // read answer stands only in the cycle after the strobe
        if (regRd) begin
            case (regAddr)
                OFS_CTRL: begin
                    st_nxt.rdData[CTRL_EXT_BIT] = st_r.extEn;
                end
                OFS_STATUS: begin
                    st_nxt.rdData[STS_CLS_LSB +: 3] = st_r.cls;
                    st_nxt.rdData[STS_NOP_BIT] = st_r.nop;
                    st_nxt.rdData[STS_SEQ_BIT] = st_r.seq;
                    st_nxt.rdData[STS_JMP_BIT] = st_r.pendJump;
                    st_nxt.rdData[STS_CND_BIT] = st_r.pendCond;
                    st_nxt.rdData[STS_EXT_BIT] = st_r.extOp;
                end
                OFS_CYCLES: begin
                    st_nxt.rdData[15:0] = st_r.cycCnt;
                end
                OFS_LASTWORD: begin
                    st_nxt.rdData[15:0] = st_r.lastWord;
                end
                default: begin
                    st_nxt.rdData = 32'h0000_0000;
                end
            endcase
        end
        if (cycEnd) begin
            st_nxt.cycCnt = st_r.cycCnt + 16'h0001;
        end
        // clear wins over the count: software wants a clean zero
        if (regWr && regAddr == OFS_CTRL) begin
            st_nxt.extEn = regWdata[CTRL_EXT_BIT];
            if (regWdata[CTRL_CLR_BIT]) begin
                st_nxt.cycCnt = 16'h0000;
            end
        end
        if (cycEnd) begin
            // default every cycle to a harmless nop with no write enables
            st_nxt.fetch = 1'b1;
            st_nxt.lastWord = instrWord;
            st_nxt.issue = 1'b1;
            st_nxt.nop = 1'b1;
            st_nxt.cls = CLS_NOP;
            st_nxt.wrAcc = 1'b0;
            st_nxt.wrFile = 1'b0;
            st_nxt.shadow = 1'b0;
            st_nxt.tblOp = 1'b0;
            st_nxt.ptrLoad = 1'b0;
            st_nxt.pcLoad = 1'b0;
            st_nxt.condEval = 1'b0;
            st_nxt.extOp = 1'b0;
            st_nxt.pendCond = 1'b0;
            st_nxt.pendJump = 1'b0;
            st_nxt.opc = instrWord[15:10];
            if (st_r.seq == SQ_WORD2) begin
                // both words in hand: issue the double-word instruction
                st_nxt.seq = SQ_EXEC;
                st_nxt.nop = 1'b0;
                st_nxt.cls = CLS_DWORD;
                st_nxt.opc = st_r.word1[15:10];
                case (st_r.word1[15:12])
                    NIB_DW_MOVE: begin
                        st_nxt.srcAddr = st_r.word1[11:0];
                        st_nxt.dstAddr = instrWord[11:0];
                        st_nxt.wrFile = 1'b1;
                    end
                    NIB_DW_CALL: begin
                        st_nxt.progAddr = {instrWord[11:0], st_r.word1[7:0]};
                        st_nxt.shadow = st_r.word1[8];
                        st_nxt.pcLoad = 1'b1;
                    end
                    NIB_DW_GOTO: begin
                        st_nxt.progAddr = {instrWord[11:0], st_r.word1[7:0]};
                        st_nxt.pcLoad = 1'b1;
                    end
                    default: begin
                        // pointer load with a 12-bit constant
                        st_nxt.ptrSel = st_r.word1[5:4];
                        st_nxt.literal = {st_r.word1[3:0], instrWord[7:0]};
                        st_nxt.ptrLoad = 1'b1;
                    end
                endcase
            end else if (killWord) begin
                // stale word dropped; a dropped first word leaves its
                // second word to arrive next and run as nop as well
                st_nxt.nop = 1'b1;
            end else if (isDword(instrWord)) begin
                // first word: wait one cycle for the second, writing nothing
                st_nxt.seq = SQ_WORD2;
                st_nxt.word1 = instrWord;
                st_nxt.issue = 1'b0;
            end else begin
                // single word: route the fields of its class
                st_nxt.nop = 1'b0;
                st_nxt.cls = classOf(instrWord);
                st_nxt.fileAddr = instrWord[7:0];
                st_nxt.banked = instrWord[8];
                st_nxt.destFile = instrWord[9];
                st_nxt.effAddr = bankAddr(instrWord[8], instrWord[7:0], bankSelectReg);
                st_nxt.bitSel = instrWord[11:9];
                st_nxt.literal = {4'h0, instrWord[7:0]};
                st_nxt.relOff = instrWord[7:0];
                case (classOf(instrWord))
                    CLS_BYTE: begin
                        st_nxt.wrAcc = ~instrWord[9];
                        st_nxt.wrFile = instrWord[9];
                    end
                    CLS_BIT: begin
                        // bit test skips the next word when true
                        if (instrWord[15:12] == NIB_BIT_TEST) begin
                            st_nxt.condEval = 1'b1;
                            st_nxt.pendCond = 1'b1;
                        end else begin
                            st_nxt.wrFile = 1'b1;
                        end
                    end
                    CLS_LIT: begin
                        if (instrWord[11:8] >= SUB_EXT_LO) begin
                            st_nxt.extOp = st_r.extEn;
                            st_nxt.extIdx = {1'b1, instrWord[9:8]};
                            st_nxt.nop = ~st_r.extEn;
                            st_nxt.cls = st_r.extEn ? CLS_LIT : CLS_NOP;
                        end else begin
                            st_nxt.wrAcc = (instrWord[11:8] != SUB_NONE);
                        end
                    end
                    CLS_CTRL: begin
                        if (instrWord[11:8] <= SUB_CBR_MAX) begin
                            st_nxt.condEval = 1'b1;
                            st_nxt.condCode = instrWord[10:8];
                            st_nxt.pendCond = 1'b1;
                        end else if (instrWord[11:8] == SUB_RETURN) begin
                            st_nxt.shadow = instrWord[0];
                            st_nxt.pcLoad = 1'b1;
                            st_nxt.pendJump = 1'b1;
                        end else if (instrWord[11:8] == SUB_TABLE) begin
                            st_nxt.tblOp = 1'b1;
                            st_nxt.tblMode = midt_tbl_t'(instrWord[1:0]);
                        end else if (instrWord[11:8] == SUB_JUMP) begin
                            st_nxt.pcLoad = 1'b1;
                            st_nxt.pendJump = 1'b1;
                        end else if (instrWord[11:8] >= SUB_EXT_LO) begin
                            st_nxt.extOp = st_r.extEn;
                            st_nxt.extIdx = {1'b0, instrWord[9:8]};
                            st_nxt.nop = ~st_r.extEn;
                            st_nxt.cls = st_r.extEn ? CLS_CTRL : CLS_NOP;
                        end
                    end
                    default: begin
                        st_nxt.nop = 1'b1;
                    end
                endcase
            end
        end
    end

    // single register stage for all state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign fetchReq = st_r.fetch;
    assign cycPhase = phase;
    assign issueStb = st_r.issue;
    assign nopCycle = st_r.nop;
    assign instrClass = st_r.cls;
    assign opcField = st_r.opc;
    assign fileAddr = st_r.fileAddr;
    assign effAddr = st_r.effAddr;
    assign bankedAccess = st_r.banked;
    assign destToFile = st_r.destFile;
    assign bitSel = st_r.bitSel;
    assign literalVal = st_r.literal;
    assign indirectPointerSel = st_r.ptrSel;
    assign indirectPointerLoad = st_r.ptrLoad;
    assign condEval = st_r.condEval;
    assign condCode = st_r.condCode;
    assign relOffset = st_r.relOff;
    assign pcLoad = st_r.pcLoad;
    assign progAddr = st_r.progAddr;
    assign shadowUpd = st_r.shadow;
    assign tableOp = st_r.tblOp;
    assign tableAddressPointerMode = st_r.tblMode;
    assign srcAddr = st_r.srcAddr;
    assign dstAddr = st_r.dstAddr;
    assign workingAccumulatorWr = st_r.wrAcc;
    assign fileWr = st_r.wrFile;
    assign extOp = st_r.extOp;
    assign extIdx = st_r.extIdx;
    assign regRdata = st_r.rdData;

    // checks on the sequencer and the decoded outputs
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_cycle_four;
        cycEnd |=> !cycEnd [*3] ##1 cycEnd;
    endproperty
    a_cycle_four: assert property (p_cycle_four) else $error("instruction cycle not four periods");

    property p_dest_sel;
        issueStb && instrClass == CLS_BYTE |-> (workingAccumulatorWr != destToFile) && (fileWr == destToFile);
    endproperty
    a_dest_sel: assert property (p_dest_sel) else $error("byte op destination misrouted");

    property p_access_bank;
        cycEnd && st_r.seq == SQ_EXEC && !killWord && classOf(instrWord) == CLS_BYTE
            |=> effAddr == {$past(instrWord[8]) ? $past(bankSelectReg) : ($past(instrWord[7]) ? ACC_HI_BANK : ACC_LO_BANK),
                $past(instrWord[7:0])};
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("effective address bank wrong");

    property p_lone_second;
        cycEnd && st_r.seq == SQ_EXEC && instrWord[15:12] == NIB_SECOND |=> nopCycle && !fileWr && !pcLoad;
    endproperty
    a_lone_second: assert property (p_lone_second) else $error("lone second word not a nop");

    property p_dword_two;
        cycEnd && st_r.seq == SQ_EXEC && !killWord && isDword(instrWord)
            |=> !issueStb [*4] ##1 (issueStb && !nopCycle && instrClass == CLS_DWORD);
    endproperty
    a_dword_two: assert property (p_dword_two) else $error("double word not issued after two cycles");

    property p_skip_nop;
        cycEnd && st_r.seq == SQ_EXEC && st_r.pendCond && condTrue
            |=> nopCycle && !workingAccumulatorWr && !fileWr && !shadowUpd && !tableOp && !pcLoad;
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("taken test did not insert a clean nop");

    property p_jump_nop;
        issueStb && pcLoad && instrClass == CLS_CTRL ##3 cycEnd |=> nopCycle && !indirectPointerLoad;
    endproperty
    a_jump_nop: assert property (p_jump_nop) else $error("jump not followed by nop cycle");

    sequence s_skip_over_dword;
        cycEnd && st_r.seq == SQ_EXEC && killWord && isDword(instrWord) ##4 cycEnd;
    endsequence
    property p_skip_three;
        s_skip_over_dword |=> nopCycle && issueStb;
    endproperty
    a_skip_three: assert property (p_skip_three) else $error("skip over double word not three cycles");

    property p_shadow_off;
        cycEnd && st_r.seq == SQ_EXEC && !killWord && instrWord[15:12] == NIB_CTRL
            && instrWord[11:8] == SUB_RETURN && !instrWord[0] |=> !shadowUpd && pcLoad;
    endproperty
    a_shadow_off: assert property (p_shadow_off) else $error("shadow touched with selector zero");

    property p_fetch_once;
        fetchReq |=> !fetchReq [*3] ##1 fetchReq;
    endproperty
    a_fetch_once: assert property (p_fetch_once) else $error("fetch not once per cycle");

    // main scenarios
    c_skip_taken: cover property (cycEnd && st_r.pendCond && condTrue);
    c_dword: cover property (issueStb && instrClass == CLS_DWORD);
    c_skip_dword: cover property (s_skip_over_dword);
    c_ext: cover property (issueStb && extOp);
endmodule

// [dv/midt_far_model.sv]
// program memory and datapath stand-in facing the decoder
`timescale 1ns/1ns
module midt_far_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fetch side
    input wire logic fetchReq,
    output logic [15:0] instrWord,
    // datapath side
    input wire logic condEval,
    input wire logic [2:0] condCode,
    output logic condTrue
);
    logic [15:0] mem [0:63];
    logic [5:0] pcIdx;
    // sequential fetch only; jump targets are not followed
    assign instrWord = mem[pcIdx];
    // test outcome is code bit 0; outside tests it toggles so stale values are noticed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pcIdx <= 6'h00;
            condTrue <= 1'b0;
        end else begin
            pcIdx <= pcIdx + {5'h00, fetchReq};
            condTrue <= condEval ? condCode[0] : ~condTrue;
        end
    end
endmodule

// [dv/mcu_instruction_decode_timing_tb.sv]
// self-checking bench for the instruction decode and timing block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module mcu_instruction_decode_timing_tb import midt_pkg::*;;
    logic clk_sys, rst_n, fetchReq, condTrue, issueStb, nopCycle, bankedAccess, destToFile, indirectPointerLoad;
    logic condEval, pcLoad, shadowUpd, tableOp, workingAccumulatorWr, fileWr, extOp, regWr, regRd;
    logic [1:0] cycPhase, indirectPointerSel;
    logic [2:0] bitSel, condCode, extIdx;
    logic [3:0] bankSelectReg;
    logic [5:0] opcField;
    logic [7:0] fileAddr, relOffset, regAddr;
    logic [11:0] effAddr, literalVal, srcAddr, dstAddr;
    logic [15:0] instrWord;
    logic [19:0] progAddr;
    logic [31:0] regWdata, regRdata, rd;
    midt_class_t instrClass;
    midt_tbl_t tableAddressPointerMode;
    int errors = 0, n_compared = 0, gap = 0, ticks = 0;
    logic [15:0] prog [0:30] = '{16'h0312, 16'h0090, 16'h7A05, 16'h90AB, 16'hA900, 16'hA901, 16'hA902,
        16'hA903, 16'hA205, 16'hA305, 16'h0000, 16'hA307, 16'hE034, 16'hF567, 16'hE034, 16'hF567, 16'h9D00,
        16'hF000, 16'hA801, 16'h0312, 16'hA800, 16'h0000, 16'hAB12, 16'h0312, 16'hD134, 16'hF9AB, 16'hC123,
        16'hF456, 16'hB025, 16'hF0CD, 16'h8A05};

    midt_decoder dut (.*);
    midt_far_model m (.*);

    // clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // bound wait for the next decode, counting oscillator periods
    task nextIssue;
        gap = 0;
        do begin
            @(posedge clk_sys);
            #1;
            gap++;
        end while (issueStb !== 1'b1 && gap < 40);
    endtask

    // one register cycle; read data taken in the cycle after the strobe
    task regAcc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= wr;
        regRd <= ~wr;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1;
        rd = regRdata;
    endtask

    task t_single;
        nextIssue();
        `CHK("class0", CLS_BYTE, instrClass)
        `CHK("dest1", 4'b0111, {nopCycle, destToFile, fileWr, bankedAccess})
        `CHK("eff0", 12'h312, effAddr)
        `CHK("opc0", 6'h00, opcField)
        `CHK("fetch", {1'b1, 2'h0, 8'h12}, {fetchReq, cycPhase, fileAddr})
        nextIssue();
        `CHK("dest0", 3'b100, {workingAccumulatorWr, fileWr, destToFile})
        `CHK("eff1", 12'hF90, effAddr)
        nextIssue();
        `CHK("bitcls", CLS_BIT, instrClass)
        `CHK("bit", {3'h5, 12'h005}, {bitSel, effAddr})
        `CHK("gap", 4, gap)
        nextIssue();
        `CHK("lit", {CLS_LIT, 12'h0AB}, {instrClass, literalVal})
        $display("single-word decode done");
    endtask

    task t_table;
        for (int md = 0; md < 4; md++) begin
            nextIssue();
            `CHK("tbl", {1'b1, midt_tbl_t'(md)}, {tableOp, tableAddressPointerMode})
        end
        $display("table modes done");
    endtask

    task t_skip;
        nextIssue();
        `CHK("test", {1'b1, 3'h2, 8'h05}, {condEval, condCode, relOffset})
        nextIssue();
        `CHK("untaken", 2'b10, {condEval, nopCycle})
        nextIssue();
        `CHK("nop", 4'b1000, {nopCycle, fileWr, workingAccumulatorWr, pcLoad})
        nextIssue();
        nextIssue();
        `CHK("skip1", 1'b1, nopCycle)
        nextIssue();
        `CHK("skip2", {1'b1, CLS_NOP}, {nopCycle, instrClass})
        `CHK("skipgap", 4, gap)
        $display("conditional skips done");
    endtask

    task t_dword;
        nextIssue();
        `CHK("dwgap", 8, gap)
        `CHK("goto", {CLS_DWORD, 1'b1, 20'h56734}, {instrClass, pcLoad, progAddr})
        nextIssue();
        `CHK("ext", {1'b1, 3'h5}, {extOp, extIdx})
        nextIssue();
        `CHK("lone", {1'b1, CLS_NOP}, {nopCycle, instrClass})
        $display("double words done");
    endtask

    // returns, jump, call, move, pointer load and bit test
    task t_ctrl;
        nextIssue();
        `CHK("ret1", {CLS_CTRL, 2'b11}, {instrClass, pcLoad, shadowUpd})
        nextIssue();
        `CHK("retnop", 4'b1000, {nopCycle, fileWr, workingAccumulatorWr, shadowUpd})
        nextIssue();
        `CHK("ret0", 2'b10, {pcLoad, shadowUpd})
        nextIssue();
        nextIssue();
        `CHK("jump", {1'b1, 8'h12}, {pcLoad, relOffset})
        nextIssue();
        `CHK("jumpnop", 2'b10, {nopCycle, pcLoad})
        nextIssue();
        `CHK("call", {CLS_DWORD, 2'b11, 20'h9AB34}, {instrClass, pcLoad, shadowUpd, progAddr})
        `CHK("callgap", 8, gap)
        nextIssue();
        `CHK("move", {12'h123, 12'h456, 1'b1}, {srcAddr, dstAddr, fileWr})
        nextIssue();
        `CHK("ptr", {1'b1, 2'h2, 12'h5CD}, {indirectPointerLoad, indirectPointerSel, literalVal})
        nextIssue();
        `CHK("bittest", {2'b10, 3'h5}, {condEval, fileWr, bitSel})
        $display("control and double-word paths done");
    endtask

    task t_regs;
        regAcc(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        regAcc(1'b1, 8'h10, 32'hFFFFFFFF);
        regAcc(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        regAcc(1'b0, OFS_LASTWORD, 32'h0);
        `CHK("lastword", 32'h0000F000, rd)
        regAcc(1'b1, OFS_CTRL, 32'h101);
        regAcc(1'b0, OFS_CYCLES, 32'h0);
        `CHK("cleared", 1'b1, rd < 32'h2)
        $display("registers done");
    endtask

    // hang guard, well beyond the roughly 160 clock periods of the run
    always @(posedge clk_sys) begin
        ticks++;
        if (ticks == 3000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        bankSelectReg = 4'h3;
        for (int i = 0; i < 64; i++)
            m.mem[i] = (i < 31) ? prog[i] : 16'hF000;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // extended set must be on before its word arrives
        regAcc(1'b1, OFS_CTRL, 32'h1);
        t_single();
        t_table();
        t_skip();
        t_dword();
        t_ctrl();
        t_regs();
        test_done();
    end
endmodule
